// >>> dual_dac_pkg.sv
package dual_dac_pkg;
  // timing base
  localparam int unsigned CLK_MHZ      = 125;     // pclk rate
  localparam int unsigned WAKE_FULL_NS = 13000;   // full power-down exit, 13 us
  localparam int unsigned WAKE_PART_NS = 1600;    // single channel exit, 1.6 us
  localparam int unsigned WAKE_W       = 11;      // wake timer width
  // least times round up to whole cycles
  localparam logic [WAKE_W-1:0] WAKE_FULL_CYC = WAKE_W'((WAKE_FULL_NS * CLK_MHZ + 999) / 1000);
  localparam logic [WAKE_W-1:0] WAKE_PART_CYC = WAKE_W'((WAKE_PART_NS * CLK_MHZ + 999) / 1000);
  localparam logic [WAKE_W-1:0] WAKE_ZERO     = 11'h000;
  // serial frame
  localparam int unsigned CNT_W      = 5;         // bit counter width
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10; // bits per frame
  localparam logic [CNT_W-1:0] CNT_ZERO   = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;
  // load function codes
  localparam logic [1:0] LF_BOTH   = 2'h0;        // shift data to both converters
  localparam logic [1:0] LF_INPUT  = 2'h1;        // shift data to one input register
  localparam logic [1:0] LF_COPY   = 2'h2;        // input register to converter
  localparam logic [1:0] LF_DIRECT = 2'h3;        // shift data to one converter
  // apb map
  localparam logic [11:0] ADDR_STATUS = 12'h000;  // live state
  localparam logic [11:0] ADDR_INPUT  = 12'h004;  // input registers
  localparam logic [11:0] ADDR_CONV   = 12'h008;  // converter registers
  localparam logic [11:0] ADDR_CTRL   = 12'h00c;  // link enable
  localparam logic        CTRL_RST    = 1'h1;     // link enabled after reset
  localparam logic [7:0]  CODE_ZERO   = 8'h00;
  // 16-bit frame, msb first
  typedef struct packed {
    logic       ref_source_select;
    logic       spare;
    logic       sync_load_bit;
    logic       chan_b_sleep;
    logic       chan_a_sleep;
    logic       chan_sel;
    logic       load_func_hi;
    logic       load_func_lo;
    logic [7:0] data;
  } frame_type;
  // analog-side controls
  typedef struct packed {
    logic [7:0] code_a;
    logic [7:0] code_b;
    logic       ref_external;
    logic       sleep_a;
    logic       sleep_b;
    logic       bias_off;
    logic       valid_a;
    logic       valid_b;
  } dac_ctl_type;
endpackage : dual_dac_pkg

// >>> dual_dac_load_sequencer.sv
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module dual_dac_load_sequencer (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     wire_clock,
  input  wire logic                     frame_sel_n,
  input  wire logic                     serial_data,
  output dual_dac_pkg::dac_ctl_type     dac_ctl
);
  // synchronisers, stage 0 feeds stage 1 only
  logic [2:0]                           clk_sync_ff;   // clock, extra stage for edges
  logic [2:0]                           sel_sync_ff;   // frame select, extra stage
  logic [1:0]                           dat_sync_ff;   // serial data
  logic [15:0]                          shift_ff;      // input shift register
  logic [dual_dac_pkg::CNT_W-1:0]       cnt_ff;        // bits taken this frame
  logic [1:0][7:0]                      in_ff;         // input registers, 0 = a
  logic [1:0][7:0]                      dac_ff;        // converter registers
  logic [1:0][7:0]                      nxt_in;
  logic [1:0][7:0]                      nxt_dac;
  logic [1:0]                           sleep_ff;      // per channel power-down
  logic                                 ref_ext_ff;    // external reference chosen
  logic                                 por_hold_ff;   // no write since reset
  logic [1:0][dual_dac_pkg::WAKE_W-1:0] wake_ff;       // wake timers
  logic                                 link_en_ff;    // software link enable
  logic [31:0]                          prdata_ff;
  logic                                 pslverr_ff;
  logic                                 clk_rise;      // wire clock edge seen
  logic                                 sel_rise;      // frame end seen
  logic                                 exec;          // full frame to act on
  logic                                 sel_low;
  dual_dac_pkg::frame_type              fr;            // decoded frame
  logic                                 ch;            // selected channel
  logic [1:0][dual_dac_pkg::WAKE_W-1:0] dark_ff;       // cycles awake but still settling

  // two load function bits read as one code
  function automatic logic [1:0] load_code(input dual_dac_pkg::frame_type f);
    load_code = {f.load_func_hi, f.load_func_lo};
  endfunction : load_code

  // two flops on every pin before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sync_ff <= 3'h0;
      sel_sync_ff <= 3'h7;
      dat_sync_ff <= 2'h0;
    end else begin
      clk_sync_ff <= {clk_sync_ff[1:0], wire_clock};
      sel_sync_ff <= {sel_sync_ff[1:0], frame_sel_n};
      dat_sync_ff <= {dat_sync_ff[0], serial_data};
    end
  end

  // edge detection on the second and third stages
  assign clk_rise = clk_sync_ff[1] & ~clk_sync_ff[2];
  assign sel_rise = sel_sync_ff[1] & ~sel_sync_ff[2];
  assign sel_low  = ~sel_sync_ff[1];
  // a frame acts only with all sixteen bits in
  assign exec     = sel_rise & link_en_ff & (cnt_ff == dual_dac_pkg::FRAME_BITS);
  assign fr       = dual_dac_pkg::frame_type'(shift_ff);
  assign ch       = fr.chan_sel;

  // shift register and bit count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_ff <= 16'h0000;
      cnt_ff   <= dual_dac_pkg::CNT_ZERO;
    end else if (!sel_low) begin
      // select high: nothing shifts, count restarts
      cnt_ff <= dual_dac_pkg::CNT_ZERO;
    end else if (clk_rise) begin
      // msb arrives first, so shift toward the top
      shift_ff <= {shift_ff[14:0], dat_sync_ff[1]};
      if (cnt_ff != dual_dac_pkg::FRAME_BITS) begin
        cnt_ff <= cnt_ff + dual_dac_pkg::CNT_ONE;
      end
    end
  end

  // load decode for input and converter registers
  always_comb begin
    nxt_in  = in_ff;
    nxt_dac = dac_ff;
    if (fr.sync_load_bit) begin
      // write input, then update both converters together
      nxt_in[ch] = fr.data;
      nxt_dac    = nxt_in;
    end else begin
      unique case (load_code(fr))
        dual_dac_pkg::LF_BOTH: begin
          nxt_dac[0] = fr.data;
          nxt_dac[1] = fr.data;
        end
        dual_dac_pkg::LF_INPUT: begin
          nxt_in[ch] = fr.data;
          // converters still transparent before the first write
          if (por_hold_ff) begin
            nxt_dac = nxt_in;
          end
        end
        dual_dac_pkg::LF_COPY: begin
          nxt_dac[ch] = in_ff[ch];
        end
        dual_dac_pkg::LF_DIRECT: begin
          nxt_dac[ch] = fr.data;
        end
      endcase
    end
  end

  // data registers; sleep bits never touch them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_ff       <= {dual_dac_pkg::CODE_ZERO, dual_dac_pkg::CODE_ZERO};
      dac_ff      <= {dual_dac_pkg::CODE_ZERO, dual_dac_pkg::CODE_ZERO};
      por_hold_ff <= 1'b1;
    end else if (exec) begin
      in_ff       <= nxt_in;
      dac_ff      <= nxt_dac;
      por_hold_ff <= 1'b0;
    end
  end

  // reference and power-down mode bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_ext_ff <= 1'b0;
      sleep_ff   <= 2'h0;
    end else if (exec) begin
      ref_ext_ff <= fr.ref_source_select;
      sleep_ff   <= {fr.chan_b_sleep, fr.chan_a_sleep};
    end
  end

  // wake timers, started when a channel leaves power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_ff <= {dual_dac_pkg::WAKE_ZERO, dual_dac_pkg::WAKE_ZERO};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (exec && sleep_ff[i]
            && !(i == 0 ? fr.chan_a_sleep : fr.chan_b_sleep)) begin
          // bias was off only if both slept
          if (&sleep_ff) begin
            wake_ff[i] <= dual_dac_pkg::WAKE_FULL_CYC;
          end else begin
            wake_ff[i] <= dual_dac_pkg::WAKE_PART_CYC;
          end
        end else if (wake_ff[i] != dual_dac_pkg::WAKE_ZERO) begin
          wake_ff[i] <= wake_ff[i] - 11'h001;
        end
      end
    end
  end

  // cycles each awake channel has spent settling, for the wake checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dark_ff <= {dual_dac_pkg::WAKE_ZERO, dual_dac_pkg::WAKE_ZERO};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sleep_ff[i] || wake_ff[i] == dual_dac_pkg::WAKE_ZERO) begin
          // asleep or settled: nothing to count
          dark_ff[i] <= dual_dac_pkg::WAKE_ZERO;
        end else begin
          dark_ff[i] <= dark_ff[i] + 11'h001;
        end
      end
    end
  end

  // software control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_en_ff <= dual_dac_pkg::CTRL_RST;
    end else if (psel && penable && pwrite && paddr == dual_dac_pkg::ADDR_CTRL) begin
      link_en_ff <= pwdata[0];
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      unique case (paddr)
        dual_dac_pkg::ADDR_STATUS: prdata_ff <= {23'h000000, cnt_ff, por_hold_ff,
                                                 dac_ctl.valid_b, dac_ctl.valid_a,
                                                 ref_ext_ff};
        dual_dac_pkg::ADDR_INPUT:  prdata_ff <= {16'h0000, in_ff};
        dual_dac_pkg::ADDR_CONV:   prdata_ff <= {16'h0000, dac_ff};
        dual_dac_pkg::ADDR_CTRL:   prdata_ff <= {29'h00000000, sleep_ff, link_en_ff};
        default:                   pslverr_ff <= 1'b1;
      endcase
    end
  end

  // bus handshake: always ready in the access phase
  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

  // analog side controls
  assign dac_ctl.code_a       = dac_ff[0];
  assign dac_ctl.code_b       = dac_ff[1];
  assign dac_ctl.ref_external = ref_ext_ff;
  assign dac_ctl.sleep_a      = sleep_ff[0];
  assign dac_ctl.sleep_b      = sleep_ff[1];
  assign dac_ctl.bias_off     = &sleep_ff;
  assign dac_ctl.valid_a      = !sleep_ff[0] && wake_ff[0] == dual_dac_pkg::WAKE_ZERO;
  assign dac_ctl.valid_b      = !sleep_ff[1] && wake_ff[1] == dual_dac_pkg::WAKE_ZERO;

  // checks
  AST_NO_SHIFT_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    !sel_low |=> cnt_ff == dual_dac_pkg::CNT_ZERO)
    else $error("count moved while select high");
  AST_SHORT_DROP: assert property (@(posedge pclk) disable iff (!presetn)
    sel_rise && cnt_ff != dual_dac_pkg::FRAME_BITS |=> $stable(in_ff) && $stable(dac_ff)
    && $stable(sleep_ff) && $stable(ref_ext_ff))
    else $error("short frame changed state");
  AST_BOTH_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    exec && !fr.sync_load_bit && !fr.load_func_hi && !fr.load_func_lo
    |=> dac_ff[0] == $past(fr.data) && dac_ff[1] == $past(fr.data))
    else $error("both converters not loaded");
  AST_INPUT_WR: assert property (@(posedge pclk) disable iff (!presetn)
    exec && !fr.sync_load_bit && !fr.load_func_hi && fr.load_func_lo
    |=> in_ff[$past(ch)] == $past(fr.data) && in_ff[!$past(ch)] == $past(in_ff[!ch]))
    else $error("input register write wrong");
  AST_COPY: assert property (@(posedge pclk) disable iff (!presetn)
    exec && !fr.sync_load_bit && fr.load_func_hi && !fr.load_func_lo
    |=> dac_ff[$past(ch)] == $past(in_ff[ch]) && $stable(in_ff))
    else $error("copy to converter wrong");
  AST_DIRECT: assert property (@(posedge pclk) disable iff (!presetn)
    exec && !fr.sync_load_bit && fr.load_func_hi && fr.load_func_lo
    |=> dac_ff[$past(ch)] == $past(fr.data) && $stable(in_ff))
    else $error("direct converter write wrong");
  AST_SYNC_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    exec && fr.sync_load_bit |=> in_ff[$past(ch)] == $past(fr.data) && dac_ff == in_ff)
    else $error("sync load wrong");
  AST_REF: assert property (@(posedge pclk) disable iff (!presetn)
    exec |=> dac_ctl.ref_external == $past(fr.ref_source_select))
    else $error("reference select not taken");
  AST_SLEEP: assert property (@(posedge pclk) disable iff (!presetn)
    exec |=> dac_ctl.sleep_a == $past(fr.chan_a_sleep) && dac_ctl.sleep_b == $past(fr.chan_b_sleep))
    else $error("sleep bits not taken");
  AST_BIAS: assert property (@(posedge pclk) disable iff (!presetn)
    exec |=> dac_ctl.bias_off == ($past(fr.chan_a_sleep) && $past(fr.chan_b_sleep)))
    else $error("bias state wrong");
  AST_FULL_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    exec && (&sleep_ff) && !fr.chan_a_sleep
    |=> wake_ff[0] == dual_dac_pkg::WAKE_FULL_CYC ##0 !dac_ctl.valid_a [*8])
    else $error("full wake interval wrong");
  AST_PART_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    exec && sleep_ff == 2'h2 && !fr.chan_b_sleep
    |=> wake_ff[1] == dual_dac_pkg::WAKE_PART_CYC ##0 !dac_ctl.valid_b [*8])
    else $error("partial wake interval wrong");
  AST_POR: assert property (@(posedge pclk) disable iff (!presetn)
    por_hold_ff |-> dac_ff == 16'h0000 && in_ff == 16'h0000)
    else $error("reset state not zero");

  // intake and bus checks
  AST_CNT_MAX: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_ff <= dual_dac_pkg::FRAME_BITS)
    else $error("bit count past sixteen");
  AST_SHIFT_IN: assert property (@(posedge pclk) disable iff (!presetn)
    sel_low && clk_rise |=> shift_ff[0] == $past(dat_sync_ff[1]))
    else $error("serial bit not shifted in");
  AST_LINK_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    sel_rise && !link_en_ff |=> $stable(in_ff) && $stable(dac_ff)
    && $stable(sleep_ff) && $stable(ref_ext_ff))
    else $error("disabled link changed state");
  AST_REG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !exec |=> $stable(in_ff) && $stable(dac_ff))
    else $error("registers moved without a frame");
  AST_BAD_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr != dual_dac_pkg::ADDR_STATUS
    && paddr != dual_dac_pkg::ADDR_INPUT && paddr != dual_dac_pkg::ADDR_CONV
    && paddr != dual_dac_pkg::ADDR_CTRL |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  AST_CTRL_WR: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && paddr == dual_dac_pkg::ADDR_CTRL
    |=> link_en_ff == $past(pwdata[0]))
    else $error("link enable not written");
  AST_STATUS_RD: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr == dual_dac_pkg::ADDR_STATUS
    |=> prdata[0] == $past(ref_ext_ff) && prdata[3] == $past(por_hold_ff))
    else $error("status word wrong");

  // power-on, sleep and wake interval checks
  AST_POR_THRU: assert property (@(posedge pclk) disable iff (!presetn)
    exec && por_hold_ff && !fr.sync_load_bit && load_code(fr) == dual_dac_pkg::LF_INPUT
    |=> dac_ff == in_ff)
    else $error("converters not transparent before first write");
  AST_SLEEP_DARK_A: assert property (@(posedge pclk) disable iff (!presetn)
    exec && fr.chan_a_sleep |=> !dac_ctl.valid_a)
    else $error("sleeping channel a shown valid");
  AST_SLEEP_DARK_B: assert property (@(posedge pclk) disable iff (!presetn)
    exec && fr.chan_b_sleep |=> !dac_ctl.valid_b)
    else $error("sleeping channel b shown valid");
  AST_FULL_WAKE_B: assert property (@(posedge pclk) disable iff (!presetn)
    exec && (&sleep_ff) && !fr.chan_b_sleep
    |=> wake_ff[1] == dual_dac_pkg::WAKE_FULL_CYC ##0 !dac_ctl.valid_b [*8])
    else $error("full wake interval wrong on b");
  AST_PART_WAKE_A: assert property (@(posedge pclk) disable iff (!presetn)
    exec && sleep_ff == 2'h1 && !fr.chan_a_sleep
    |=> wake_ff[0] == dual_dac_pkg::WAKE_PART_CYC ##0 !dac_ctl.valid_a [*8])
    else $error("partial wake interval wrong on a");
  AST_RUN_A: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(dac_ctl.valid_a) |-> dark_ff[0] == dual_dac_pkg::WAKE_FULL_CYC
    || dark_ff[0] == dual_dac_pkg::WAKE_PART_CYC)
    else $error("channel a woke after wrong interval");
  AST_RUN_B: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(dac_ctl.valid_b) |-> dark_ff[1] == dual_dac_pkg::WAKE_FULL_CYC
    || dark_ff[1] == dual_dac_pkg::WAKE_PART_CYC)
    else $error("channel b woke after wrong interval");
endmodule : dual_dac_load_sequencer

// >>> host_serial_model.sv
`timescale 1ns/1ps
// host side of the three-wire link; clock parked low between frames
module host_serial_model (
  input  wire logic pclk,
  output logic      wire_clock,
  output logic      frame_sel_n,
  output logic      serial_data
);
  // idle levels
  initial begin
    wire_clock  = 1'b0;
    frame_sel_n = 1'b1;
    serial_data = 1'b0;
  end
  // send the top n bits of w as a byte host does: two bytes, one select
  task automatic send_frame(input logic [15:0] w, input int n);
    @(posedge pclk);
    frame_sel_n <= 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      serial_data <= w[i];
      repeat (4) @(posedge pclk);
      wire_clock <= 1'b1;
      repeat (4) @(posedge pclk);
      wire_clock <= 1'b0;
      if (i == 8) repeat (6) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
    frame_sel_n <= 1'b1;
    serial_data <= ~serial_data; // released line loses its value
    repeat (8) @(posedge pclk);
  endtask : send_frame
endmodule : host_serial_model

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                      pclk    = 1'b0;   // 125 mhz
  logic                      presetn = 1'b0;   // async reset
  logic                      psel    = 1'b0;
  logic                      penable = 1'b0;
  logic                      pwrite  = 1'b0;
  logic [11:0]               paddr   = 12'h000;
  logic [31:0]               pwdata  = 32'h0000_0000;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      wire_clock;
  logic                      frame_sel_n;
  logic                      serial_data;
  dual_dac_pkg::dac_ctl_type dac_ctl;          // analog-side controls
  logic [31:0]               rd;               // last read word
  logic                      err;              // last error response
  int                        fail_count = 0;
  int                        checked    = 0;
  // clock
  always #4 pclk = ~pclk;
  dual_dac_load_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wire_clock(wire_clock),
    .frame_sel_n(frame_sel_n), .serial_data(serial_data), .dac_ctl(dac_ctl));
  host_serial_model host_u (.pclk(pclk), .wire_clock(wire_clock),
    .frame_sel_n(frame_sel_n), .serial_data(serial_data));
  // verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // compare a register word
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  // compare an output field
  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    chk_reg({24'h0, got}, {24'h0, exp});
  endtask : chk_out
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      give_verdict();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // converter codes at the outputs and both input registers
  task automatic codes(input logic [7:0] a, b, ia, ib);
    chk_out(dac_ctl.code_a, a);
    chk_out(dac_ctl.code_b, b);
    apb(1'b0, dual_dac_pkg::ADDR_INPUT, 32'h0);
    chk_reg(rd, {16'h0, ib, ia});
  endtask : codes
  // frame then sleep_a, sleep_b, bias_off
  task automatic sleep_chk(input logic [15:0] w, input logic [2:0] e);
    host_u.send_frame(w, 16);
    chk_out({5'h0, dac_ctl.sleep_a, dac_ctl.sleep_b, dac_ctl.bias_off}, {5'h0, e});
  endtask : sleep_chk
  // outputs not both valid now, both valid again within the window
  task automatic wake(input int lo, input int hi);
    int n;
    n = 0;
    chk_out(8'(dac_ctl.valid_a & dac_ctl.valid_b), 8'h00);
    while ((dac_ctl.valid_a & dac_ctl.valid_b) !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) begin
      fail_count++;
      give_verdict();
    end
    chk_reg(32'(n >= lo && n <= hi), 32'h1);
  endtask : wake
  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    codes(8'h00, 8'h00, 8'h00, 8'h00);
    chk_out({5'h0, dac_ctl.ref_external, dac_ctl.valid_a, dac_ctl.valid_b}, 8'h03);
    apb(1'b0, dual_dac_pkg::ADDR_STATUS, 32'h0);
    chk_reg(rd, 32'h0000_000e);
    apb(1'b0, dual_dac_pkg::ADDR_CTRL, 32'h0);
    chk_reg(rd, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk_reg({rd[30:0], err}, 32'h1);
    host_u.send_frame(16'h80a5, 16);
    codes(8'ha5, 8'ha5, 8'h00, 8'h00);
    chk_out(8'(dac_ctl.ref_external), 8'h01);
    host_u.send_frame(16'h013c, 16);
    codes(8'ha5, 8'ha5, 8'h3c, 8'h00);
    chk_out(8'(dac_ctl.ref_external), 8'h00);
    host_u.send_frame(16'h057e, 16);
    codes(8'ha5, 8'ha5, 8'h3c, 8'h7e);
    host_u.send_frame(16'h06ff, 16);
    codes(8'ha5, 8'h7e, 8'h3c, 8'h7e);
    host_u.send_frame(16'h0311, 16);
    codes(8'h11, 8'h7e, 8'h3c, 8'h7e);
    host_u.send_frame(16'h2322, 16);
    codes(8'h22, 8'h7e, 8'h22, 8'h7e);
    apb(1'b0, dual_dac_pkg::ADDR_CONV, 32'h0);
    chk_reg(rd, 32'h0000_7e22);
    host_u.send_frame(16'h80ff, 12);
    codes(8'h22, 8'h7e, 8'h22, 8'h7e);
    chk_out(8'(dac_ctl.ref_external), 8'h00);
    apb(1'b1, dual_dac_pkg::ADDR_CTRL, 32'h0);
    apb(1'b0, dual_dac_pkg::ADDR_CTRL, 32'h0);
    chk_reg(rd, 32'h0);
    host_u.send_frame(16'h80ee, 16);
    codes(8'h22, 8'h7e, 8'h22, 8'h7e);
    apb(1'b1, dual_dac_pkg::ADDR_CTRL, 32'h1);
    sleep_chk(16'h0a00, 3'b100);
    codes(8'h22, 8'h7e, 8'h22, 8'h7e);
    sleep_chk(16'h0200, 3'b000);
    wake(192, 200);
    sleep_chk(16'h1200, 3'b010);
    sleep_chk(16'h0200, 3'b000);
    wake(192, 200);
    sleep_chk(16'h1a00, 3'b111);
    codes(8'h22, 8'h7e, 8'h22, 8'h7e);
    sleep_chk(16'h0200, 3'b000);
    wake(1617, 1625);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    codes(8'h00, 8'h00, 8'h00, 8'h00);
    host_u.send_frame(16'h013c, 16);
    codes(8'h3c, 8'h00, 8'h3c, 8'h00);
    give_verdict();
  end
endmodule : tb_top
